/* design/tfpw_timer.v */
// Timer channel with free-running and pulse width measurement modes
//
// The register offsets and the strobed register port were left to the implementer.
`default_nettype none
`include "tfpw_regs.vh"

// What this block does
// - Two compare registers match independently
// - Free-run capture keeps counter running
// - Overflow flag cleared by bit or write
// - Early capture may store FFFFH
// - Mode 110 selects pulse width measurement
// - Counting starts when run bit set
// - Pulse capture stores, clears counter, interrupts
// - Wrap at FFFFH raises overflow, sets flag
module tfpw_timer #(
	parameter PWM_CAPABLE = 1
) (
	// Clock and reset
	input wire clk,
	input wire rst,
	// Register port
	input wire [7:0] reg_addr,
	input wire [15:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [15:0] reg_rdata,
	// Trigger pins and external event
	input wire first_trigger_pin,
	input wire second_trigger_pin,
	input wire ext_event_pin,
	// Interrupt outputs
	output reg capture_irq0,
	output reg capture_irq1,
	output reg overflow_irq,
	output wire irq
);

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	reg run_ff; // count_run_bit
	reg ext_sel_ff; // external_event_select
	reg [2:0] mode_ff; // mode_select_field
	reg [3:0] edge_ff; // edge_select_reg, two bits per trigger
	reg ccs0_ff; // first_cc_function_select
	reg ccs1_ff; // second_cc_function_select
	reg ovf_ff; // overflow_flag
	reg [15:0] ccr0_ff;
	reg [15:0] ccr1_ff;
	reg [15:0] cnt_ff;
	reg [2:0] irq_st_ff;
	reg [2:0] irq_msk_ff;
	reg [7:0] presc_ff; // Count clock divider, 0 means every cycle
	reg [7:0] div_ff;
	reg run_d_ff; // First count tick seen since the run bit was set

	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------
	reg [2:0] sync1_ff;
	reg [2:0] sync2_ff;
	reg [2:0] prev_ff;
	// Pins come from outside; two flops before any use
	always @(posedge clk) begin
		if (rst) begin
			sync1_ff <= 3'h0;
			sync2_ff <= 3'h0;
			prev_ff <= 3'h0;
		end else begin
			sync1_ff <= {ext_event_pin, second_trigger_pin, first_trigger_pin};
			sync2_ff <= sync1_ff;
			prev_ff <= sync2_ff;
		end
	end

	// ----------------------------------------
	// Edge detection per trigger
	// ----------------------------------------
	wire [1:0] trig_edge;
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi = gi + 1) begin : g_edge
			wire rise = sync2_ff[gi] & ~prev_ff[gi];
			wire fall = ~sync2_ff[gi] & prev_ff[gi];
			wire [1:0] sel = edge_ff[2*gi+1:2*gi];
			// No-edge setting disables the input entirely
			assign trig_edge[gi] = ((sel == `TFPW_EDGE_RISE) & rise) |
				((sel == `TFPW_EDGE_FALL) & fall) |
				((sel == `TFPW_EDGE_BOTH) & (rise | fall));
		end
	endgenerate
	wire ext_edge = sync2_ff[2] & ~prev_ff[2];

	// ----------------------------------------
	// Count clock enable
	// ----------------------------------------
	wire div_tick = (div_ff == presc_ff);
	wire pwm_mode = (mode_ff == `TFPW_MODE_PWM) && (PWM_CAPABLE != 0);
	wire count_en = run_ff & ((ext_sel_ff & ~pwm_mode) ? ext_edge : div_tick);
	always @(posedge clk) begin
		if (rst || !run_ff || div_tick)
			div_ff <= 8'h00;
		else
			div_ff <= div_ff + 8'h01;
	end

	// ----------------------------------------
	// Decode of bus writes
	// ----------------------------------------
	wire wr_opt = reg_wr && (reg_addr == `TFPW_OFF_OPT);
	wire wr_ovfclr = reg_wr && (reg_addr == `TFPW_OFF_OVFCLR);
	wire wr_irqst = reg_wr && (reg_addr == `TFPW_OFF_IRQST);
	// The idle FFFFH to 0000H step on the first tick is a start, not a wrap
	wire wrap = count_en && run_d_ff && (cnt_ff == `TFPW_CNT_MAX);
	// Captures only happen in capture role or in pulse width mode
	wire cap0 = run_ff & trig_edge[0] & (ccs0_ff | pwm_mode);
	wire cap1 = run_ff & trig_edge[1] & (ccs1_ff | pwm_mode);
	wire cmp0 = count_en & ~ccs0_ff & ~pwm_mode & (cnt_ff == ccr0_ff);
	wire cmp1 = count_en & ~ccs1_ff & ~pwm_mode & (cnt_ff == ccr1_ff);

	// ----------------------------------------
	// Counter
	// ----------------------------------------
	// Counter idles at FFFFH so the first count lands on 0000H
	always @(posedge clk) begin
		if (rst) begin
			cnt_ff <= `TFPW_CNT_MAX;
		end else if (!run_ff) begin
			cnt_ff <= `TFPW_CNT_MAX;
		end else if (pwm_mode && (cap0 || cap1)) begin
			cnt_ff <= `TFPW_CNT_ZERO;
		end else if (count_en) begin
			cnt_ff <= cnt_ff + 16'h0001;
		end
	end

	// ----------------------------------------
	// Capture / compare storage and control
	// ----------------------------------------
	always @(posedge clk) begin
		if (rst) begin
			run_ff <= 1'b0;
			run_d_ff <= 1'b0;
			ext_sel_ff <= 1'b0;
			mode_ff <= `TFPW_MODE_FREE;
			edge_ff <= 4'h0;
			ccs0_ff <= 1'b0;
			ccs1_ff <= 1'b0;
			ccr0_ff <= `TFPW_CNT_ZERO;
			ccr1_ff <= `TFPW_CNT_ZERO;
			irq_msk_ff <= 3'h0;
			presc_ff <= `TFPW_RST_PRESC;
		end else begin
			// Armed by the first tick, dropped whenever counting stops
			run_d_ff <= run_ff & (run_d_ff | count_en);
			if (reg_wr) begin
				case (reg_addr)
				`TFPW_OFF_CTRL: begin
					run_ff <= reg_wdata[`TFPW_CTRL_RUN];
					ext_sel_ff <= reg_wdata[`TFPW_CTRL_EEE];
				end
				`TFPW_OFF_MODE: begin
					mode_ff <= reg_wdata[2:0];
				end
				`TFPW_OFF_EDGE: edge_ff <= reg_wdata[3:0];
				`TFPW_OFF_OPT: begin
					ccs0_ff <= reg_wdata[`TFPW_OPT_CCS0];
					ccs1_ff <= reg_wdata[`TFPW_OPT_CCS1];
				end
				// Compare values take effect at once
				`TFPW_OFF_CCR0: if (!ccs0_ff && !pwm_mode) ccr0_ff <= reg_wdata;
				`TFPW_OFF_CCR1: if (!ccs1_ff && !pwm_mode) ccr1_ff <= reg_wdata;
				`TFPW_OFF_IRQMSK: irq_msk_ff <= reg_wdata[2:0];
				`TFPW_OFF_PRESC: presc_ff <= reg_wdata[7:0];
				default: begin
				end
				endcase
			end
			if (cap0)
				ccr0_ff <= cnt_ff;
			if (cap1)
				ccr1_ff <= cnt_ff;
		end
	end

	// ----------------------------------------
	// Overflow flag and interrupt pulses
	// ----------------------------------------
	always @(posedge clk) begin
		if (rst) begin
			ovf_ff <= 1'b0;
			overflow_irq <= 1'b0;
			capture_irq0 <= 1'b0;
			capture_irq1 <= 1'b0;
		end else begin
			overflow_irq <= wrap;
			capture_irq0 <= cap0 | cmp0;
			capture_irq1 <= cap1 | cmp1;
			if (wrap)
				ovf_ff <= 1'b1;
			else if (wr_ovfclr || (wr_opt && !reg_wdata[`TFPW_OPT_OVF]))
				ovf_ff <= 1'b0;
		end
	end

	// ----------------------------------------
	// Interrupt status and mask
	// ----------------------------------------
	wire [2:0] irq_evt = {wrap, cap1 | cmp1, cap0 | cmp0};
	genvar gj;
	generate
		for (gj = 0; gj < 3; gj = gj + 1) begin : g_irq
			// Write one clears; a new event in the same cycle wins
			always @(posedge clk) begin
				if (rst)
					irq_st_ff[gj] <= 1'b0;
				else if (irq_evt[gj])
					irq_st_ff[gj] <= 1'b1;
				else if (wr_irqst && reg_wdata[gj])
					irq_st_ff[gj] <= 1'b0;
			end
		end
	endgenerate
	assign irq = |(irq_st_ff & irq_msk_ff);

	// ----------------------------------------
	// Read path, data one cycle after strobe
	// ----------------------------------------
	always @(posedge clk) begin
		if (rst) begin
			reg_rdata <= 16'h0000;
		end else if (reg_rd) begin
			case (reg_addr)
			`TFPW_OFF_CTRL: reg_rdata <= {14'h0000, ext_sel_ff, run_ff};
			`TFPW_OFF_MODE: reg_rdata <= {13'h0000, mode_ff};
			`TFPW_OFF_EDGE: reg_rdata <= {12'h000, edge_ff};
			`TFPW_OFF_OPT: reg_rdata <= {10'h000, ccs1_ff, ccs0_ff, 3'h0, ovf_ff};
			`TFPW_OFF_CCR0: reg_rdata <= ccr0_ff;
			`TFPW_OFF_CCR1: reg_rdata <= ccr1_ff;
			// Stopped counter reads as zero
			`TFPW_OFF_CNT: reg_rdata <= run_ff ? cnt_ff : `TFPW_CNT_ZERO;
			`TFPW_OFF_IRQST: reg_rdata <= {13'h0000, irq_st_ff};
			`TFPW_OFF_IRQMSK: reg_rdata <= {13'h0000, irq_msk_ff};
			`TFPW_OFF_PRESC: reg_rdata <= {8'h00, presc_ff};
			default: reg_rdata <= 16'h0000;
			endcase
		end else begin
			reg_rdata <= 16'h0000;
		end
	end

endmodule // tfpw_timer
`default_nettype wire

/* design/tfpw_regs.vh */
// Register offsets, field positions, modes, edge codes, counter values and reset values of the timer channel
`ifndef TFPW_REGS_VH
`define TFPW_REGS_VH
// ----------------------------------------
// Register offsets (8-bit index)
// ----------------------------------------
`define TFPW_OFF_CTRL 8'h00
`define TFPW_OFF_MODE 8'h01
`define TFPW_OFF_EDGE 8'h02
`define TFPW_OFF_OPT 8'h03
`define TFPW_OFF_OVFCLR 8'h04
`define TFPW_OFF_CCR0 8'h05
`define TFPW_OFF_CCR1 8'h06
`define TFPW_OFF_CNT 8'h07
`define TFPW_OFF_IRQST 8'h08
`define TFPW_OFF_IRQMSK 8'h09
`define TFPW_OFF_PRESC 8'h0A
// ----------------------------------------
// Field positions
// ----------------------------------------
`define TFPW_CTRL_RUN 0
`define TFPW_CTRL_EEE 1
`define TFPW_OPT_OVF 0
`define TFPW_OPT_CCS0 4
`define TFPW_OPT_CCS1 5
`define TFPW_IRQ_CC0 0
`define TFPW_IRQ_CC1 1
`define TFPW_IRQ_OV 2
// ----------------------------------------
// Modes, edges, values
// ----------------------------------------
`define TFPW_MODE_FREE 3'h5
`define TFPW_MODE_PWM 3'h6
`define TFPW_EDGE_NONE 2'h0
`define TFPW_EDGE_RISE 2'h1
`define TFPW_EDGE_FALL 2'h2
`define TFPW_EDGE_BOTH 2'h3
`define TFPW_CNT_MAX 16'hFFFF
`define TFPW_CNT_ZERO 16'h0000
`define TFPW_RST_PRESC 8'h00
`endif

/* sim/tfpw_chk_properties.sv */
// Port checker of the timer channel
`default_nettype none
module tfpw_chk (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic reg_rd,
	input wire logic [15:0] reg_rdata,
	// Interrupts
	input wire logic capture_irq0,
	input wire logic capture_irq1,
	input wire logic overflow_irq,
	input wire logic irq
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	AST_RST_QUIET: assert property (disable iff (1'b0) rst |=> !irq && !overflow_irq
		&& !capture_irq0 && !capture_irq1) else $error("output active after reset");
	AST_RD_IDLE: assert property (!reg_rd |=> reg_rdata == 16'h0000)
		else $error("read data without a read");
	AST_RD_UNMAP: assert property (reg_rd && reg_addr > 8'h0A |=> reg_rdata == 16'h0000)
		else $error("unmapped index read nonzero");
	AST_CC0_PULSE: assert property (capture_irq0 |=> !capture_irq0)
		else $error("capture pulse 0 too long");
	AST_CC1_PULSE: assert property (capture_irq1 |=> !capture_irq1)
		else $error("capture pulse 1 too long");
	// A wrap needs a full counter cycle, so pulses stand far apart
	AST_OV_GAP: assert property (overflow_irq |=> !overflow_irq [*8])
		else $error("overflow pulses too close");
	AST_OV_FLAG: assert property ($past(overflow_irq) && reg_rd && reg_addr == 8'h03
		|=> reg_rdata[0]) else $error("overflow flag not set with pulse");
	AST_CC_STAT: assert property ($past(capture_irq0) && reg_rd && reg_addr == 8'h08
		|=> reg_rdata[0]) else $error("capture status not set with pulse");
	// Main scenarios reached
	COV_CC0: cover property (capture_irq0);
	COV_CC1: cover property (capture_irq1);
	COV_OV: cover property (overflow_irq);
endmodule // tfpw_chk
bind tfpw_timer tfpw_chk tfpw_chk_inst (.clk(clk), .rst(rst), .reg_addr(reg_addr),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata), .capture_irq0(capture_irq0),
	.capture_irq1(capture_irq1), .overflow_irq(overflow_irq), .irq(irq));
`default_nettype wire

/* sim/tfpw_pulse_src.sv */
// Pulse source model on the trigger and event pins
`default_nettype none
module tfpw_pulse_src (
	// Clock and commands
	input wire logic clk,
	input wire logic fire0,
	// Pins
	output var logic pin0,
	output var logic pin1,
	output var logic evt
);
	timeunit 1ns;
	timeprecision 1ps;
	// Pins start low
	initial begin
		pin0 = 1'b0;
		pin1 = 1'b0;
		evt = 1'b0;
	end
	// each command flips the pin, so both edge kinds occur
	always @(posedge clk) begin
		pin0 <= pin0 ^ fire0;
		evt <= ~evt;
	end
endmodule // tfpw_pulse_src
`default_nettype wire

/* sim/timer_free_run_pulse_width_bench.sv */
// Self-checking bench of the timer channel
`default_nettype none
`include "tfpw_regs.vh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin error_cnt++; \
	$display("MISMATCH %0t got %h exp %h", $time, g, e); end end
module timer_free_run_pulse_width_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, want = 1'b0, mon = 1'b0;
	logic fire = 1'b0, pin0, pin1, evt, cc0, cc1, ov, irq;
	logic [7:0] reg_addr = 8'h00;
	logic [15:0] reg_wdata = 16'h0000, rdata, v1, v2, c0, g, ex, sink;
	logic [15:0] exq[$];
	int error_cnt = 0, compares = 0, cyc = 0, t0, seed = 32'hf747;
	// Clock and cycle count
	always #5 clk = ~clk;
	always @(posedge clk) cyc <= cyc + 1;
	tfpw_timer tfpw_timer_inst (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata), .first_trigger_pin(pin0),
		.second_trigger_pin(pin1), .ext_event_pin(evt), .capture_irq0(cc0),
		.capture_irq1(cc1), .overflow_irq(ov), .irq(irq));
	tfpw_pulse_src tfpw_pulse_src_inst (.clk(clk), .fire0(fire), .pin0(pin0), .pin1(pin1),
		.evt(evt));
	// Read data stand one cycle after the strobe: take the oldest note
	always @(posedge clk) begin
		if (mon) begin
			ex = exq.pop_front();
			`CHK(rdata, ex)
		end
		mon <= reg_rd & want;
	end
	task automatic results();
		if (error_cnt == 0 && compares > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// Strobes drop for a cycle, so no signal is set twice in one step
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rd(input logic [7:0] a, input logic w, output logic [15:0] v);
		reg_rd <= 1'b1;
		want <= w;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(posedge clk);
		v = rdata;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [15:0] e);
		exq.push_back(e);
		rd(a, 1'b1, sink);
	endtask
	// Bounded wait for one interrupt pulse: 0 capture 0, 1 capture 1, 2 overflow
	task automatic wt(input int w, input int lim);
		int n;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (((({ov, cc1, cc0}) >> w) & 3'h1) !== 3'h1 && n < lim);
		if (n >= lim) begin
			error_cnt++;
			results();
		end
	endtask
	task automatic fire_at(input int t);
		while (cyc < t) @(posedge clk);
		fire <= 1'b1;
		@(posedge clk);
		fire <= 1'b0;
	endtask
	initial begin
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rdc(`TFPW_OFF_MODE, 16'h0005);
		rdc(8'h0F, 16'h0000);
		// Two compares off one counter, spacing known
		c0 = 16'h0040 + 16'($random(seed) & 63);
		g = 16'h0010 + 16'($random(seed) & 63);
		wr(`TFPW_OFF_CCR0, c0);
		wr(`TFPW_OFF_CCR1, c0 + g);
		wr(`TFPW_OFF_IRQMSK, 16'h0003);
		wr(`TFPW_OFF_CTRL, 16'h0001);
		wt(0, 400);
		t0 = cyc;
		wt(1, 400);
		`CHK(16'(cyc - t0), g)
		`CHK(irq, 1'b1)
		wr(`TFPW_OFF_IRQMSK, 16'h0000);
		`CHK(irq, 1'b0)
		wr(`TFPW_OFF_IRQMSK, 16'h0003);
		wr(`TFPW_OFF_IRQST, 16'h0003);
		`CHK(irq, 1'b0)
		// Next interval added to the previous compare value
		g = 16'h0100 + 16'($random(seed) & 255);
		wr(`TFPW_OFF_CCR0, c0 + g);
		wt(0, 700);
		`CHK(16'(cyc - t0), g)
		// Captures on both edges, counter left running
		g = 16'h0028 + 16'($random(seed) & 63);
		wr(`TFPW_OFF_OPT, 16'h0010);
		wr(`TFPW_OFF_EDGE, 16'h0003);
		t0 = cyc;
		fire_at(t0);
		wt(0, 20);
		rd(`TFPW_OFF_CCR0, 1'b0, v1);
		fire_at(t0 + g);
		wt(0, 20);
		rd(`TFPW_OFF_CCR0, 1'b0, v2);
		`CHK(16'(v2 - v1), g)
		// Pulse width mode, rise to rise on the first pin only
		// internal clock, second pin set to no edge
		// one capture register, gaps well under a counter cycle
		wr(`TFPW_OFF_CTRL, 16'h0000);
		wr(`TFPW_OFF_MODE, 16'h0006);
		wr(`TFPW_OFF_OPT, 16'h0000);
		wr(`TFPW_OFF_EDGE, 16'h0001);
		wr(`TFPW_OFF_CTRL, 16'h0001);
		wr(`TFPW_OFF_IRQST, 16'h0007);
		t0 = cyc;
		fire_at(t0);
		fire_at(t0 + 3);
		fire_at(t0 + g);
		wt(0, 20);
		rdc(`TFPW_OFF_IRQST, 16'h0001);
		rdc(`TFPW_OFF_CCR0, g - 16'h0001);
		// No further edge for a full counter cycle
		wt(2, 70000);
		rdc(`TFPW_OFF_OPT, 16'h0001);
		wr(`TFPW_OFF_OVFCLR, 16'h0001);
		rdc(`TFPW_OFF_OPT, 16'h0000);
		@(posedge clk);
		results();
	end
endmodule // timer_free_run_pulse_width_bench
`default_nettype wire
